/* exec_core.v */
// Execution core for bit branches, bit set, branch never, subroutine branch,
// flag clears, clear, complement and the two compares.
// Assumes opcode and operand bytes arrive on op_byte while fetch_req is high.
`timescale 1ns/1ps
`include "core_exec_regs.vh"
// Notes on behaviour
// - Bit clear branch: if tested bit zero, pc becomes pc plus 3 plus offset.
// - Bit clear opcodes odd 01..0f, bit index from opcode 3:1, five cycles.
// - Bit set branch: if tested bit one, pc plus 3 plus offset.
// - Bit set branch opcodes even 00..0e, bit index opcode 3:1, five cycles.
// - Both bit branches copy tested bit into carry; other flags kept.
// - Bit operand address is one byte, reaching only 0000..00ff.
// - Branch never, 21, skips offset, pc plus 2, three cycles, no flags.
// - Bit set writes selected bit one, keeps others and flags, five cycles.
// - Subroutine branch ad: return is pc plus 2, target return plus offset.
// - Push low return byte, decrement stack, push high byte, decrement again.
// - Clear carry, 98, clears carry in two cycles, other flags kept.
// - Index compare subtracts memory from index, sets n and z, stores nothing.
// - Index compare carry from borrow formula on operand and result signs.
module exec_core (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [7:0] op_byte,
  input wire irq_pending,
  output reg [15:0] pc,
  output reg [7:0] sp,
  output reg [7:0] accumulator,
  output reg [7:0] index_reg,
  output reg [7:0] condition_flags,
  output wire fetch_req,
  output reg irq_take,
  output reg illegal_op,
  output reg busy
);
  localparam S_FETCH = 3'd0;
  localparam S_OPER1 = 3'd1;
  localparam S_OPER2 = 3'd2;
  localparam S_MEMRD = 3'd3;
  localparam S_EXEC = 3'd4;
  localparam S_WAIT = 3'd5;
  reg [2:0] state;
  reg [7:0] opcode;
  reg [7:0] dir_addr;
  reg [7:0] rel;
  reg [3:0] cyc;
  reg [3:0] cyc_len;
  reg push_hi;
  reg mask_clear_pend;
  reg irq_block;
  reg [7:0] next_addr;
  reg next_we;
  reg [7:0] next_wdata;
  wire [7:0] mem_rdata;
  wire [2:0] bit_n = opcode[3:1];
  wire is_bitbr = opcode[7:4] == `HI_BITTEST;
  wire is_set_memory_bit = opcode[7:4] == `HI_BITSET && !opcode[0];
  wire is_cmp = opcode == `OP_CMP_IMM || opcode == `OP_CMP_DIR;
  wire is_cpx = opcode == `OP_CPX_IMM || opcode == `OP_CPX_DIR;
  wire is_dir_mem = opcode == `OP_CMP_DIR || opcode == `OP_CPX_DIR ||
    opcode == `OP_CLRD || opcode == `OP_COMD;
  wire tested = mem_rdata[bit_n];
  assign fetch_req = state == S_FETCH || state == S_OPER1 || state == S_OPER2;

  // Sign-extended relative offset add
  function [15:0] rel_add;
    input [15:0] base;
    input [7:0] off;
    begin
      rel_add = base + {{8{off[7]}}, off};
    end
  endfunction

  // Compare flags: n, z and borrow from register, memory and difference signs
  function [2:0] cmp_flags;
    input [7:0] r;
    input [7:0] m;
    reg [7:0] d;
    begin
      d = r - m;
      cmp_flags = {d[7], d == 8'h00,
        (~r[7] & m[7]) | (m[7] & d[7]) | (d[7] & ~r[7])};
    end
  endfunction

  // Total cycles for an opcode
  function [3:0] op_cycles;
    input [7:0] op;
    begin
      if (op[7:4] == `HI_BITTEST) begin
        op_cycles = `CYC_BITBR;
      end else if (op[7:4] == `HI_BITSET && !op[0]) begin
        op_cycles = `CYC_SET_MEMORY_BIT;
      end else begin
        case (op)
          `OP_BRN: op_cycles = `CYC_BRN;
          `OP_BSR: op_cycles = `CYC_BSR;
          `OP_CLC, `OP_CLI: op_cycles = `CYC_INH;
          `OP_CLRA, `OP_CLRX, `OP_COMA, `OP_COMX: op_cycles = `CYC_ACC;
          `OP_CLRD, `OP_COMD: op_cycles = `CYC_DIRRMW;
          `OP_CMP_IMM, `OP_CPX_IMM: op_cycles = `CYC_IMM;
          `OP_CMP_DIR, `OP_CPX_DIR: op_cycles = `CYC_DIR;
          default: op_cycles = 4'h0;
        endcase
      end
    end
  endfunction

  // High on the last cycle of the instruction in progress
  function last_cyc;
    input [3:0] count;
    input [3:0] len;
    begin
      last_cyc = count + 4'h1 >= len;
    end
  endfunction

  // Memory port steering: direct page reads, writes and stack pushes
  always @* begin
    next_addr = dir_addr;
    next_we = 1'b0;
    next_wdata = 8'h00;
    // Start the operand read as its address streams in, saving a cycle
    if (state == S_OPER1) begin
      next_addr = op_byte;
    end
    if (state == S_EXEC) begin
      if (is_set_memory_bit) begin
        next_we = 1'b1;
        next_wdata = mem_rdata | (8'h01 << bit_n);
      end else if (opcode == `OP_CLRD) begin
        next_we = 1'b1;
        next_wdata = 8'h00;
      end else if (opcode == `OP_COMD) begin
        next_we = 1'b1;
        next_wdata = ~mem_rdata;
      end else if (opcode == `OP_BSR) begin
        // Stack sits in the direct page; only the low address byte is used
        next_addr = sp;
        next_we = 1'b1;
        next_wdata = push_hi ? pc[15:8] : pc[7:0];
      end
    end
  end

  mem_page #(.AW(8), .DW(8)) u_mem (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .addr(next_addr),
    .we(next_we),
    .wdata(next_wdata),
    .rdata(mem_rdata)
  );

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= S_FETCH;
      pc <= `PC_RESET;
      sp <= `SP_RESET;
      accumulator <= 8'h00;
      index_reg <= 8'h00;
      condition_flags <= `FLAGS_RESET;
      opcode <= 8'h00;
      dir_addr <= 8'h00;
      rel <= 8'h00;
      cyc <= 4'h0;
      cyc_len <= 4'h0;
      push_hi <= 1'b0;
      mask_clear_pend <= 1'b0;
      irq_block <= 1'b0;
      irq_take <= 1'b0;
      illegal_op <= 1'b0;
      busy <= 1'b0;
    end else if (clk_en) begin
      irq_take <= 1'b0;
      illegal_op <= 1'b0;
      if (mask_clear_pend) begin
        condition_flags[`FLAG_I] <= 1'b0;
        mask_clear_pend <= 1'b0;
      end
      if (state != S_FETCH) begin
        cyc <= cyc + 4'h1;
      end
      case (state)
        S_FETCH: begin
          // Interrupts are only sampled here, and never right after a mask clear
          if (irq_pending && !condition_flags[`FLAG_I] && !irq_block) begin
            irq_take <= 1'b1;
          end else begin
            opcode <= op_byte;
            cyc_len <= op_cycles(op_byte);
            cyc <= 4'h1;
            pc <= pc + 16'h0001;
            irq_block <= 1'b0;
            busy <= 1'b1;
            if (op_cycles(op_byte) == 4'h0) begin
              illegal_op <= 1'b1;
              busy <= 1'b0;
            end else if (op_byte == `OP_CLC || op_byte == `OP_CLI ||
                op_byte == `OP_CLRA || op_byte == `OP_CLRX ||
                op_byte == `OP_COMA || op_byte == `OP_COMX) begin
              state <= S_EXEC;
            end else begin
              state <= S_OPER1;
            end
          end
        end
        S_OPER1: begin
          pc <= pc + 16'h0001;
          if (opcode == `OP_BRN || opcode == `OP_BSR) begin
            rel <= op_byte;
            state <= S_EXEC;
          end else if (is_cmp || is_cpx) begin
            dir_addr <= op_byte;
            if (opcode == `OP_CMP_DIR || opcode == `OP_CPX_DIR) begin
              // Data for the streamed address arrives next cycle
              state <= S_EXEC;
            end else begin
              // Immediate form ends here to keep its two cycles
              {condition_flags[`FLAG_N], condition_flags[`FLAG_Z], condition_flags[`FLAG_C]} <=
                cmp_flags(is_cpx ? index_reg : accumulator, op_byte);
              state <= S_FETCH;
              busy <= 1'b0;
            end
          end else begin
            dir_addr <= op_byte;
            state <= is_bitbr ? S_OPER2 : S_MEMRD;
          end
        end
        S_OPER2: begin
          rel <= op_byte;
          pc <= pc + 16'h0001;
          state <= S_EXEC;
        end
        S_MEMRD: begin
          state <= S_EXEC;
        end
        S_EXEC: begin
          // Short instructions end here; longer ones pad in the wait state
          if (last_cyc(cyc, cyc_len)) begin
            state <= S_FETCH;
            busy <= 1'b0;
          end else begin
            state <= S_WAIT;
          end
          if (is_bitbr) begin
            condition_flags[`FLAG_C] <= tested;
            // pc already advanced by 3 past the opcode
            if (tested != opcode[0]) begin
              pc <= rel_add(pc, rel);
            end
          end else if (opcode == `OP_BSR) begin
            sp <= sp - 8'h01;
            if (push_hi) begin
              push_hi <= 1'b0;
              pc <= rel_add(pc, rel);
            end else begin
              push_hi <= 1'b1;
              state <= S_EXEC;
            end
          end else if (opcode == `OP_CLC) begin
            condition_flags[`FLAG_C] <= 1'b0;
          end else if (opcode == `OP_CLI) begin
            mask_clear_pend <= 1'b1;
            irq_block <= 1'b1;
          end else if (opcode == `OP_CLRA || opcode == `OP_CLRX || opcode == `OP_CLRD) begin
            if (opcode == `OP_CLRA) accumulator <= 8'h00;
            if (opcode == `OP_CLRX) index_reg <= 8'h00;
            condition_flags[`FLAG_N] <= 1'b0;
            condition_flags[`FLAG_Z] <= 1'b1;
          end else if (opcode == `OP_COMA) begin
            accumulator <= ~accumulator;
            condition_flags[`FLAG_N] <= ~accumulator[7];
            condition_flags[`FLAG_Z] <= accumulator == 8'hff;
            condition_flags[`FLAG_C] <= 1'b1;
          end else if (opcode == `OP_COMX) begin
            index_reg <= ~index_reg;
            condition_flags[`FLAG_N] <= ~index_reg[7];
            condition_flags[`FLAG_Z] <= index_reg == 8'hff;
            condition_flags[`FLAG_C] <= 1'b1;
          end else if (opcode == `OP_COMD) begin
            condition_flags[`FLAG_N] <= ~mem_rdata[7];
            condition_flags[`FLAG_Z] <= mem_rdata == 8'hff;
            condition_flags[`FLAG_C] <= 1'b1;
          end else if (is_cpx) begin
            {condition_flags[`FLAG_N], condition_flags[`FLAG_Z], condition_flags[`FLAG_C]} <=
              cmp_flags(index_reg, is_dir_mem ? mem_rdata : dir_addr);
          end else if (is_cmp) begin
            {condition_flags[`FLAG_N], condition_flags[`FLAG_Z], condition_flags[`FLAG_C]} <=
              cmp_flags(accumulator, is_dir_mem ? mem_rdata : dir_addr);
          end
        end
        S_WAIT: begin
          // Pads to the instruction's cycle count
          if (last_cyc(cyc, cyc_len)) begin
            state <= S_FETCH;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= S_FETCH;
        end
      endcase
    end
  end
endmodule

/* core_exec_regs.vh */
// Opcodes, flag positions, reset values and cycle counts for the execution core.
// Assumes inclusion once per compilation unit by bare name.
`ifndef CORE_EXEC_REGS_VH
`define CORE_EXEC_REGS_VH
`define OP_BRN 8'h21
`define OP_BSR 8'had
`define OP_CLC 8'h98
`define OP_CLI 8'h9a
`define OP_CLRA 8'h4f
`define OP_CLRX 8'h5f
`define OP_CLRD 8'h3f
`define OP_COMA 8'h43
`define OP_COMX 8'h53
`define OP_COMD 8'h33
`define OP_CMP_IMM 8'ha1
`define OP_CMP_DIR 8'hb1
`define OP_CPX_IMM 8'ha3
`define OP_CPX_DIR 8'hb3
`define HI_BITTEST 4'h0
`define HI_BITSET 4'h1
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_I 3
`define FLAG_H 4
`define FLAGS_RESET 8'he8
`define SP_RESET 8'hff
`define SP_HIGH 8'h00
`define PC_RESET 16'h0100
`define DIRECT_PAGE 8'h00
`define BIT_BRANCH_STEP 16'h0003
`define REL_STEP 16'h0002
`define CYC_BITBR 4'h5
`define CYC_SET_MEMORY_BIT 4'h5
`define CYC_BRN 4'h3
`define CYC_BSR 4'h6
`define CYC_INH 4'h2
`define CYC_ACC 4'h3
`define CYC_DIRRMW 4'h5
`define CYC_IMM 4'h2
`define CYC_DIR 4'h3
`endif

/* mem_page.v */
// Small synchronous memory holding the direct page and the stack.
// Assumes one clock; read data appear one cycle after the address.
`timescale 1ns/1ps
module mem_page #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire sys_clk,
  input wire clk_en,
  input wire [AW-1:0] addr,
  input wire we,
  input wire [DW-1:0] wdata,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge sys_clk) begin
    if (clk_en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule

/* exec_checker.sv */
// Assertion checker for the execution core, bound to its top ports.
// Assumes an opcode fetch is an enabled fetch edge with busy low.
`timescale 1ns/1ps
module exec_checker (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [7:0] op_byte,
  input wire irq_pending,
  input wire [15:0] pc,
  input wire [7:0] sp,
  input wire [7:0] accumulator,
  input wire [7:0] index_reg,
  input wire [7:0] condition_flags,
  input wire fetch_req,
  input wire irq_take,
  input wire illegal_op,
  input wire busy
);
  reg vq;
  reg [3:0] cyc;
  reg [3:0] nb;
  reg [7:0] op_q, b1, b2, fl_q, a_q, x_q, sp_q;
  reg [15:0] pc_q;
  wire start = clk_en && fetch_req && !busy;
  wire done = start && vq;
  wire tk = condition_flags[0] ^ op_q[0];
  wire [7:0] cr = (op_q == 8'ha3) ? x_q : a_q;
  wire [7:0] df = cr - b1;
  // Bit branches and bit set only; odd 1x codes are outside the group
  wire bit_op = op_q[7:5] == 3'b000 && !(op_q[4] && op_q[0]);
  // Snapshot at each opcode; judged at the next opcode fetch
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vq <= 1'b0;
      cyc <= 4'h0;
      nb <= 4'h0;
    end else if (clk_en) begin
      cyc <= start ? 4'h1 : cyc + 4'h1;
      if (start) begin
        vq <= 1'b1;
        op_q <= op_byte;
        pc_q <= pc;
        sp_q <= sp;
        fl_q <= condition_flags;
        a_q <= accumulator;
        x_q <= index_reg;
        nb <= 4'h0;
      end else if (fetch_req) begin
        nb <= nb + 4'h1;
        if (nb == 4'h0) b1 <= op_byte;
        if (nb == 4'h1) b2 <= op_byte;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_reset_vals: assert property ($fell(sys_rst) |-> pc == 16'h0100 && sp == 8'hff
    && condition_flags == 8'he8) else $error("bad values after reset");
  a_bit_branch: assert property (done && op_q[7:4] == 4'h0 |->
    pc == pc_q + 16'h0003 + (tk ? {{8{b2[7]}}, b2} : 16'h0000)
    && condition_flags[7:1] == fl_q[7:1]) else $error("bit branch pc or flags wrong");
  a_bit_cycles: assert property (done && bit_op |-> cyc == 4'h5)
    else $error("bit op cycle count wrong");
  a_brn_step: assert property (done && op_q == 8'h21 |-> pc == pc_q + 16'h0002
    && condition_flags == fl_q && cyc == 4'h3) else $error("branch never wrong");
  a_bsr_call: assert property (done && op_q == 8'had |-> sp == sp_q - 8'h02
    && pc == pc_q + 16'h0002 + {{8{b1[7]}}, b1} && cyc == 4'h6) else $error("call wrong");
  a_clc_only: assert property (done && op_q == 8'h98 |->
    condition_flags == (fl_q & 8'hfe) && cyc == 4'h2) else $error("carry clear wrong");
  a_cmp_flags: assert property (done && (op_q == 8'ha1 || op_q == 8'ha3) |->
    condition_flags == {fl_q[7:3], df[7], df == 8'h00, cr < b1}
    && accumulator == a_q && index_reg == x_q) else $error("compare flags wrong");
  a_clr_acc: assert property (done && op_q == 8'h4f |-> accumulator == 8'h00
    && condition_flags == {fl_q[7:3], 2'b01, fl_q[0]}) else $error("clear wrong");
  a_cli_delay: assert property (irq_take |-> $past(vq) && $past(op_q) != 8'h9a)
    else $error("interrupt taken straight after mask clear");
  c_call: cover property (done && op_q == 8'had);
  c_taken: cover property (done && op_q[7:4] == 4'h0 && tk);
  c_irq: cover property (irq_take);
  c_cmp_dir: cover property (done && op_q == 8'hb1);
endmodule

/* prog_rom.sv */
// Program memory model feeding the core's instruction stream.
// Assumes pc addresses bytes; only the low 1 KiB is modelled.
`timescale 1ns/1ps
module prog_rom (
  input wire [15:0] pc,
  input wire fetch_req,
  output wire [7:0] op_byte
);
  reg [7:0] mem [0:1023];
  // Inverted when not fetched, so a stale byte never looks valid
  assign op_byte = fetch_req ? mem[pc[9:0]] : ~mem[pc[9:0]];
  task fill;
    integer i;
    begin
      for (i = 0; i < 1024; i = i + 1) mem[i] = 8'h9d;
    end
  endtask
  task put(input [15:0] a, input [7:0] d0, input [7:0] d1, input [7:0] d2);
    begin
      mem[a[9:0]] = d0;
      mem[a[9:0] + 10'h1] = d1;
      mem[a[9:0] + 10'h2] = d2;
    end
  endtask
endmodule

/* bit_branch_clear_compare_exec_tb.sv */
// Self-checking bench: random bit branches, then a fixed call and mask run.
// Assumes the core fetches from prog_rom at pc.
`timescale 1ns/1ps
module bit_branch_clear_compare_exec_tb;
  reg sys_clk, sys_rst, clk_en, irq_pending, c;
  wire [7:0] op_byte, sp, accumulator, index_reg, condition_flags;
  wire [15:0] pc;
  wire fetch_req, irq_take, illegal_op, busy;
  integer err_count, comparisons, seed, k, i;
  reg [31:0] r;
  reg [7:0] dd, rr;
  reg [2:0] n, m;
  reg [15:0] land;
  exec_core dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .op_byte(op_byte),
    .irq_pending(irq_pending), .pc(pc), .sp(sp), .accumulator(accumulator),
    .index_reg(index_reg), .condition_flags(condition_flags), .fetch_req(fetch_req),
    .irq_take(irq_take), .illegal_op(illegal_op), .busy(busy));
  prog_rom rom_u (.pc(pc), .fetch_req(fetch_req), .op_byte(op_byte));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function [15:0] land_of(input [2:0] m, input [2:0] n, input c, input [7:0] rr);
    land_of = 16'h0107 + (((m == n) ^ c) ? {{8{rr[7]}}, rr} : 16'h0000);
  endfunction
  task check(input [15:0] got, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task restart;
    begin
      @(negedge sys_clk);
      sys_rst = 1'b1;
      repeat (4) @(negedge sys_clk);
      sys_rst = 1'b0;
    end
  endtask
  // Counts enabled edges only, so random stalls do not eat the budget
  task run_to(input [15:0] exp);
    begin
      i = 0;
      while (pc !== exp && i < 40) begin
        @(negedge sys_clk);
        if (clk_en) i = i + 1;
        check(irq_take, 16'h0);
        clk_en = ($random(seed) & 3) != 0;
      end
      clk_en = 1'b1;
      check(pc, exp);
    end
  endtask
  initial begin
    err_count = 0;
    comparisons = 0;
    seed = 32'hc74d07ff;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    irq_pending = 1'b0;
    for (k = 0; k < 24; k = k + 1) begin
      r = $random(seed);
      dd = 8'h20 | r[5:0];
      n = r[8:6];
      m = r[12] ? n : r[11:9];
      c = r[13];
      rr = 8'h20 | r[20:16];
      irq_pending = r[21];
      if (k == 0) begin
        // Backward branch, landing below the reset pc
        rr = 8'hf0;
        m = n;
        c = 1'b0;
      end
      land = land_of(m, n, c, rr);
      rom_u.fill;
      rom_u.put(16'h0100, 8'h3f, dd, {4'h1, n, 1'b0});
      rom_u.put(16'h0103, dd, {4'h0, m, c}, dd);
      rom_u.put(16'h0106, rr, 8'h9d, 8'h9d);
      rom_u.put(land, 8'h21, 8'h00, 8'h9d);
      restart;
      run_to(land + 16'h0002);
      check(condition_flags[0], m == n);
      // Branch never ends in three cycles, so the filler byte is fetched next
      repeat (2) @(negedge sys_clk);
      check(illegal_op, 16'h0001);
    end
    r = $random(seed);
    rom_u.fill;
    rom_u.put(16'h0100, 8'h4f, 8'h43, 8'ha1);
    rom_u.put(16'h0103, r[7:0], 8'ha3, r[15:8]);
    rom_u.put(16'h0106, 8'h98, 8'had, 8'h10);
    rom_u.put(16'h0119, 8'hb1, 8'hfe, 8'h9a);
    rom_u.put(16'h011c, 8'h43, 8'h9d, 8'h9d);
    irq_pending = 1'b1;
    restart;
    i = 0;
    while (irq_take !== 1'b1 && i < 60) begin
      @(negedge sys_clk);
      i = i + 1;
    end
    check(accumulator, 16'h0000);
    check(condition_flags, 16'h00e3);
    check(sp, 16'h00fd);
    check(irq_take, 16'h0001);
    end_sim;
  end
  initial begin
    #100000;
    err_count = err_count + 1;
    end_sim;
  end
endmodule
bind exec_core exec_checker chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .op_byte(op_byte), .irq_pending(irq_pending), .pc(pc), .sp(sp), .accumulator(accumulator),
  .index_reg(index_reg), .condition_flags(condition_flags), .fetch_req(fetch_req),
  .irq_take(irq_take), .illegal_op(illegal_op), .busy(busy));
